// ==== verilog/pwmcr_map.vh ====
`ifndef PWMCR_MAP_VH
`define PWMCR_MAP_VH

// ---------------------------------------------------------------
// register offsets (4-bit register address)
// ---------------------------------------------------------------
`define PWMCR_ADDR_W 4
`define PWMCR_CH_STRIDE 4'h4
`define PWMCR_OFF_CTRL 2'h0
`define PWMCR_OFF_DCH 2'h1
`define PWMCR_OFF_DCL 2'h2
`define PWMCR_ADDR_PERIOD 4'h8
`define PWMCR_ADDR_TIMER 4'h9
`define PWMCR_ADDR_TCTRL 4'hA

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PWMCR_BIT_ON 7
`define PWMCR_BIT_LEVEL 5
`define PWMCR_BIT_POL 4
`define PWMCR_BIT_TON 7
`define PWMCR_DCL_HI 7
`define PWMCR_DCL_LO 6

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define PWMCR_DATA_W 8
`define PWMCR_DUTY_W 10
`define PWMCR_CHANNELS 2
`define PWMCR_PERIOD_RST 8'hFF
`define PWMCR_TIMER_RST 8'h00
`define PWMCR_PHASE_LAST 2'h3
`define PWMCR_ZERO8 8'h00

`endif

// ==== verilog/pwmcr_chan.v ====
`include "pwmcr_map.vh"

module pwmcr_chan (
  input wire clk_in,
  input wire srst_in,
  input wire wr_ctrl_in,
  input wire wr_dch_in,
  input wire wr_dcl_in,
  input wire [7:0] wdata_in,
  input wire period_match_in,
  input wire [9:0] time_base_in,
  input wire [7:0] period_in,
  output wire [7:0] ctrl_rd_out,
  output wire [7:0] dch_rd_out,
  output wire [7:0] dcl_rd_out,
  output reg pin_out
);

  // ---------------------------------------------------------------
  // control and duty registers
  // ---------------------------------------------------------------
  reg module_on_bit;
  reg output_polarity_select;
  reg [9:0] duty_cycle_value;
  reg [9:0] duty_latched;
  reg active;
  reg next_active;
  reg next_pin;
  wire [9:0] period_end;
  wire overlong;
  wire [10:0] next_tb;

  always @(posedge clk_in) begin
    if (srst_in) begin
      module_on_bit <= 1'b0;
      output_polarity_select <= 1'b0;
    end else if (wr_ctrl_in) begin
      module_on_bit <= wdata_in[`PWMCR_BIT_ON];
      output_polarity_select <= wdata_in[`PWMCR_BIT_POL];
    end
  end

  // duty bits have no reset: undefined at power-up, kept across resets
  always @(posedge clk_in) begin
    if (wr_dch_in) begin
      duty_cycle_value[9:2] <= wdata_in;
    end
    if (wr_dcl_in) begin
      duty_cycle_value[1:0] <= wdata_in[`PWMCR_DCL_HI:`PWMCR_DCL_LO];
    end
    if (period_match_in) begin
      duty_latched <= duty_cycle_value;
    end
  end

  // ---------------------------------------------------------------
  // waveform
  // ---------------------------------------------------------------
  assign period_end = {period_in, `PWMCR_PHASE_LAST};
  assign overlong = (duty_latched > period_end);
  // pin is registered, so decide on the time base of the coming cycle
  assign next_tb = {1'b0, time_base_in} + 11'h001;

  always @* begin
    next_active = active;
    if (period_match_in) begin
      next_active = (duty_cycle_value != 10'h000);
    end else if (active && !overlong && (next_tb >= {1'b0, duty_latched})) begin
      next_active = 1'b0;
    end
    if (module_on_bit) begin
      next_pin = next_active ^ output_polarity_select;
    end else begin
      next_pin = output_polarity_select;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      active <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      active <= next_active;
      pin_out <= next_pin;
    end
  end

  // ---------------------------------------------------------------
  // read views, unused bits zero
  // ---------------------------------------------------------------
  assign ctrl_rd_out = {module_on_bit, 1'b0, pin_out, output_polarity_select, 4'h0};
  assign dch_rd_out = duty_cycle_value[9:2];
  assign dcl_rd_out = {duty_cycle_value[1:0], 6'h00};

endmodule // pwmcr_chan

// ==== verilog/pwmcr_top.v ====
`include "pwmcr_map.vh"

module pwmcr_top (
  input wire CLK_SYS_IN,
  input wire SRST_IN,
  input wire [3:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output reg [7:0] REG_RDATA_OUT,
  output wire [1:0] MODULATED_OUTPUT_PIN_OUT
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg timer_on;
  reg [7:0] period_register;
  reg [7:0] time_base_counter;
  reg [1:0] clock_phase;
  reg [7:0] next_rdata;
  wire phase_wrap;
  wire period_match;
  wire [9:0] time_base;
  wire [15:0] ctrl_rd_bus;
  wire [15:0] dch_rd_bus;
  wire [15:0] dcl_rd_bus;
  wire [1:0] ch_sel;
  wire [1:0] ch_off;
  wire ch_hit;

  // ---------------------------------------------------------------
  // address split
  // ---------------------------------------------------------------
  assign ch_sel = REG_ADDR_IN[3:2];
  assign ch_off = REG_ADDR_IN[1:0];
  assign ch_hit = (REG_ADDR_IN[3] == 1'b0);

  // ---------------------------------------------------------------
  // timer control and period registers
  // ---------------------------------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      timer_on <= 1'b0;
      period_register <= `PWMCR_PERIOD_RST;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == `PWMCR_ADDR_PERIOD) begin
        period_register <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `PWMCR_ADDR_TCTRL) begin
        timer_on <= REG_WDATA_IN[`PWMCR_BIT_TON];
      end
    end
  end

  // ---------------------------------------------------------------
  // time base: 8-bit count plus two clock phase bits
  // ---------------------------------------------------------------
  assign phase_wrap = timer_on && (clock_phase == `PWMCR_PHASE_LAST);
  assign period_match = phase_wrap && (time_base_counter == period_register);
  assign time_base = {time_base_counter, clock_phase};

  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      clock_phase <= 2'h0;
      time_base_counter <= `PWMCR_TIMER_RST;
    end else if (timer_on) begin
      clock_phase <= clock_phase + 2'h1;
      if (period_match) begin
        time_base_counter <= `PWMCR_TIMER_RST;
      end else if (phase_wrap) begin
        time_base_counter <= time_base_counter + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // modulator channels
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PWMCR_CHANNELS; gi = gi + 1) begin : g_chan
      localparam [1:0] CH_IDX = gi;
      wire sel;
      assign sel = REG_WR_IN && ch_hit && (ch_sel == CH_IDX);
      pwmcr_chan u_chan (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .wr_ctrl_in(sel && (ch_off == `PWMCR_OFF_CTRL)),
        .wr_dch_in(sel && (ch_off == `PWMCR_OFF_DCH)),
        .wr_dcl_in(sel && (ch_off == `PWMCR_OFF_DCL)),
        .wdata_in(REG_WDATA_IN),
        .period_match_in(period_match),
        .time_base_in(time_base),
        .period_in(period_register),
        .ctrl_rd_out(ctrl_rd_bus[gi*8 +: 8]),
        .dch_rd_out(dch_rd_bus[gi*8 +: 8]),
        .dcl_rd_out(dcl_rd_bus[gi*8 +: 8]),
        .pin_out(MODULATED_OUTPUT_PIN_OUT[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read decode, data one cycle after the strobe
  // ---------------------------------------------------------------
  always @* begin
    next_rdata = `PWMCR_ZERO8;
    if (ch_hit && (ch_off == `PWMCR_OFF_CTRL)) begin
      next_rdata = ctrl_rd_bus[ch_sel[0]*8 +: 8];
    end else if (ch_hit && (ch_off == `PWMCR_OFF_DCH)) begin
      next_rdata = dch_rd_bus[ch_sel[0]*8 +: 8];
    end else if (ch_hit && (ch_off == `PWMCR_OFF_DCL)) begin
      next_rdata = dcl_rd_bus[ch_sel[0]*8 +: 8];
    end else if (REG_ADDR_IN == `PWMCR_ADDR_PERIOD) begin
      next_rdata = period_register;
    end else if (REG_ADDR_IN == `PWMCR_ADDR_TIMER) begin
      next_rdata = time_base_counter;
    end else if (REG_ADDR_IN == `PWMCR_ADDR_TCTRL) begin
      next_rdata = {timer_on, 7'h00};
    end else begin
      next_rdata = `PWMCR_ZERO8;
    end
  end

  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      REG_RDATA_OUT <= `PWMCR_ZERO8;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= next_rdata;
    end else begin
      REG_RDATA_OUT <= `PWMCR_ZERO8;
    end
  end

endmodule // pwmcr_top

// ==== tb/pwmcr_monitor.sv ====
module pwmcr_monitor (
  input wire CLK_SYS_IN,
  input wire SRST_IN,
  input wire [3:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [7:0] REG_RDATA_OUT,
  input wire [1:0] MODULATED_OUTPUT_PIN_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // helper terms
  // ---------------------------------------------------------------
  wire pin0 = MODULATED_OUTPUT_PIN_OUT[0];
  wire wd4 = REG_WDATA_IN[4];
  wire [1:0] wd_hi = REG_WDATA_IN[7:6];
  wire rd_ctl = REG_RD_IN && REG_ADDR_IN == 4'h0;
  wire rd_dcl = REG_RD_IN && REG_ADDR_IN == 4'h2;
  wire wr_ctl = REG_WR_IN && REG_ADDR_IN == 4'h0;
  wire wr_dch = REG_WR_IN && REG_ADDR_IN == 4'h1;
  wire rd_dch = REG_RD_IN && REG_ADDR_IN == 4'h1;
  wire rd_ctl1 = REG_RD_IN && REG_ADDR_IN == 4'h4;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  rd_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data not idle");
  ctrl_rsvd_a: assert property (rd_ctl |=> (REG_RDATA_OUT & 8'h4F) == 8'h00)
    else $error("control reserved bits set");
  dcl_rsvd_a: assert property (rd_dcl |=> REG_RDATA_OUT[5:0] == 6'h00)
    else $error("duty low reserved bits set");
  ctrl1_rsvd_a: assert property (rd_ctl1 |=> (REG_RDATA_OUT & 8'h4F) == 8'h00)
    else $error("channel one control reserved bits set");
  level_bit_a: assert property (rd_ctl |=> REG_RDATA_OUT[5] == $past(pin0))
    else $error("level bit differs from pin");
  reset_pin_a: assert property ($fell(SRST_IN) |-> MODULATED_OUTPUT_PIN_OUT == 2'h0 ##1
    MODULATED_OUTPUT_PIN_OUT == 2'h0) else $error("pin not low after reset");
  off_level_a: assert property (wr_ctl && !REG_WDATA_IN[7] |-> ##2 pin0 == $past(wd4, 2))
    else $error("disabled pin not at polarity level");
  dch_back_a: assert property (wr_dch ##1 !REG_WR_IN ##1 rd_dch |=>
    REG_RDATA_OUT == $past(REG_WDATA_IN, 3)) else $error("duty high readback");
  dcl_back_a: assert property (REG_WR_IN && REG_ADDR_IN == 4'h2 ##1 !REG_WR_IN ##1 rd_dcl
    |=> REG_RDATA_OUT[7:6] == $past(wd_hi, 3)) else $error("duty low readback");
  cover property (pin0 ##1 !pin0);
  cover property (rd_dcl);
  cover property ($fell(SRST_IN));
endmodule // pwmcr_monitor

bind pwmcr_top pwmcr_monitor u_pwmcr_monitor (.CLK_SYS_IN(CLK_SYS_IN), .SRST_IN(SRST_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .MODULATED_OUTPUT_PIN_OUT(MODULATED_OUTPUT_PIN_OUT));

// ==== tb/pwm_control_and_duty_registers_tb.sv ====
module pwm_control_and_duty_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, d, cnt0, cnt1;
  logic [7:0] rdata;
  logic [1:0] pin;
  logic [7:0] exp_q[$];
  int error_cnt = 0, n_checks = 0, seed = 32'hA99FD972, i;
  int duty[7] = '{0, 1, 5, 15, 16, 1023, 0};
  pwmcr_top u_pwmcr_top (.CLK_SYS_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .MODULATED_OUTPUT_PIN_OUT(pin));
  // ---------------------------------------------------------------
  // clock, read monitor, tasks
  // ---------------------------------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) if (rd_q) chk("read data", rdata, exp_q.pop_front());
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wrt(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    end_sim;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 2; i++) begin
      rdx(4'(4 * i), 8'h00);
      d = 8'($random(seed));
      wrt(4'(4 * i), d & 8'h7F);
      rdx(4'(4 * i), d[4] ? 8'h30 : 8'h00);
      wrt(4'(4 * i + 1), d);
      rdx(4'(4 * i + 1), d);
      wrt(4'(4 * i + 2), ~d);
      rdx(4'(4 * i + 2), ~d & 8'hC0);
    end
    for (i = 11; i < 16; i++) begin
      wrt(4'(i), 8'hFF);
      rdx(4'(i), 8'h00);
    end
    rdx(4'h3, 8'h00);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdx(4'h4, 8'h00);
    rdx(4'h5, d);
    rdx(4'h6, ~d & 8'hC0);
    wrt(4'h8, 8'h03);
    wrt(4'hA, 8'h80);
    wrt(4'h5, 8'h00);
    wrt(4'h6, 8'h00);
    wrt(4'h4, 8'h90);
    wrt(4'h0, 8'h80);
    duty[6] = {$random(seed)} % 20;
    for (i = 0; i < 7; i++) begin
      wrt(4'h1, 8'(duty[i] >> 2));
      wrt(4'h2, 8'(duty[i] << 6));
      repeat (40) @(posedge clk);
      cnt0 = 8'h00;
      cnt1 = 8'h00;
      repeat (32) begin
        @(negedge clk);
        cnt0 += pin[0];
        cnt1 += pin[1];
      end
      chk("ch0 high count", cnt0, duty[i] > 15 ? 8'h20 : 8'(2 * duty[i]));
      chk("ch1 high count", cnt1, 8'h20);
    end
    end_sim;
  end
endmodule // pwm_control_and_duty_registers_tb
